/* File: rtl/jtag_cmd_pkg.sv */
// constants for the byte command engine: opcode fields, header flags, reset values
// assumes one command byte per handshake and one response byte per push
package jtag_cmd_pkg;

    // ==========================================================
    // command byte layout
    localparam int OP_TOP_BIT = 7;
    localparam int WALK_TDI_BIT = 6;
    localparam logic [2:0] SCAN_OPCODE = 3'h4;
    localparam int HDR_TMS_LAST_BIT = 3;
    localparam int HDR_CAPTURE_BIT = 2;
    localparam int HDR_FIXED_TDI_BIT = 1;
    localparam int HDR_FIXED_FLAG_BIT = 0;
    localparam int LEN_PACKED_BIT = 7;

    // ==========================================================
    // counts
    localparam logic [3:0] DATA_BYTE_BITS = 4'h8;
    localparam logic [2:0] RESP_LAST_IDX = 3'h7;
    localparam logic [7:0] LAST_BIT_CNT = 8'h01;

    // ==========================================================
    // reset values
    localparam logic [7:0] HDR_RESET = 8'h00;
    localparam logic [7:0] RESP_RESET = 8'h00;
    localparam logic TMS_RESET = 1'h0;
    localparam logic TDI_RESET = 1'h0;

endpackage

/* File: rtl/level_sync3.sv */
// three-stage level synchroniser with agreement filter
// assumes d is quasi-static relative to clk; rst may be tied low
`timescale 1ns/1ps

module level_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ==========================================================
    // elaboration check
    generate
        if (W < 1)
        begin : g_bad_width
            $error("level_sync3 width must be at least one");
        end
    endgenerate

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // ==========================================================
    // chain; s1 feeds only s2
    always_ff @(posedge clk)
    begin
        s1_reg <= d;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else if (s2_reg == s3_reg)
            q <= s3_reg;
    end

endmodule

/* File: rtl/jtag_byte_command_engine.sv */
// byte command engine: decodes state-walk and scan packets, serialises to the tap lines
// assumes command source upstream and response fifo downstream; link_clk runs the tap side
// What this block does
// R1: top bit zero means one-byte state-walk packet, one to five mode bits.
// R2: state-walk holds tdi at command bit 6 for every mode bit.
// R3: state-walk captures nothing and pushes no response bytes.
// R4: state-walk mode bits go out lowest first, bit 0 first.
// R5: each mode or scan bit takes exactly one test-clock cycle.
// R6: scan packet header starts 100; low four bits are subtype flags.
// R7: scan packet is header, length or packed byte, then optional data bytes.
// R8: header bit 3 gives tms on the last scan cycle.
// R9: tms low on every scan cycle before the last.
// R10: header bit 2 set captures tdo each cycle into responses.
// R11: sender must not capture with several ports selected; values undefined.
// R12: header bit 0 set holds tdi at header bit 1 all scan.
// R13: fixed-input flag clear takes tdi from later bytes; set means none.
// R14: second byte bit 7 clear: bits 6..0 are length minus one.
// R15: normal length with fixed-input flag ends packet at two bytes.
// R16: second byte bit 7 set is packed, implies length, ends packet.
// R17: sender uses packed format only for scans of six or fewer.
// R18: packed with flag clear drives tdi from bits 5..0, bit 0 first.
// R19: packed with flag set uses bits only for length; tdi fixed.
// R20: highest set bit of packed bits 6..0 marks end; position is length.
// R21: top bits 101, 110, 111 are consumed with no cycles or responses.
// R22: normal length with flag clear reads ceil(len/8) data bytes, bit 0 first.
// R23: captured bits pack into bytes, zero padded, pushed as each completes.
// R24: scan pauses while a response byte waits for fifo space.
`timescale 1ns/1ps

module jtag_byte_command_engine (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic [7:0] resp_data,
    output logic resp_valid,
    input wire logic resp_ready,
    input wire logic tdo,
    output logic tms,
    output logic tdi,
    output logic tck_en,
    output logic busy
);

    typedef enum {ST_IDLE, ST_LEN, ST_DATA, ST_SHIFT, ST_WAIT, ST_PUSH} state_t;

    // ==========================================================
    // helpers
    function automatic logic [2:0] hi_bit(input logic [6:0] v);
        logic [2:0] pos;
        pos = 3'h0;
        for (int i = 0; i < 7; i++)
        begin
            if (v[i])
                pos = 3'(i);
        end
        return pos;
    endfunction

    state_t state_reg;
    logic [7:0] hdr_reg;
    logic walk_reg;
    logic walk_tdi_reg;
    logic packed_reg;
    logic [7:0] data_reg;
    logic [3:0] data_left_reg;
    logic [7:0] bit_cnt_reg;
    logic [7:0] resp_sr_reg;
    logic [2:0] resp_cnt_reg;
    logic req_tgl_reg;
    logic ack_seen_reg;
    logic out_tms_reg;
    logic out_tdi_reg;
    logic out_cap_reg;
    logic ack_sync;
    logic link_rst;
    logic req_sync;
    logic req_seen_reg;
    logic ack_tgl_reg;
    logic lk_cap_reg;
    logic tdo_cap_reg;
    logic take;
    logic ack_evt;
    logic last_bit;
    logic need_data;
    logic resp_full;
    logic [7:0] resp_merge;
    logic [2:0] walk_len;
    logic [2:0] packed_len;

    assign take = cmd_valid && cmd_ready;
    assign ack_evt = (state_reg == ST_WAIT) && (ack_sync != ack_seen_reg);
    assign last_bit = (bit_cnt_reg == jtag_cmd_pkg::LAST_BIT_CNT);
    assign need_data = !walk_reg && !packed_reg && !hdr_reg[jtag_cmd_pkg::HDR_FIXED_FLAG_BIT];
    assign resp_full = (resp_cnt_reg == jtag_cmd_pkg::RESP_LAST_IDX) || last_bit;
    assign walk_len = hi_bit({1'h0, cmd_data[5:0]});
    assign packed_len = hi_bit(cmd_data[6:0]);

    always_comb
    begin
        resp_merge = resp_sr_reg;
        resp_merge[resp_cnt_reg] = tdo_cap_reg;
    end

    // ==========================================================
    // crossings
    level_sync3 #(.W(1)) u_ack_sync (
        .clk(clk),
        .rst(srst),
        .d(ack_tgl_reg),
        .q(ack_sync)
    );

    // reset must be held long enough to reach the link side
    level_sync3 #(.W(1)) u_rst_sync (
        .clk(link_clk),
        .rst(1'h0),
        .d(srst),
        .q(link_rst)
    );

    level_sync3 #(.W(1)) u_req_sync (
        .clk(link_clk),
        .rst(link_rst),
        .d(req_tgl_reg),
        .q(req_sync)
    );

    // ==========================================================
    // command fetch handshake
    // ready drops after each take so a byte is never taken twice
    always_ff @(posedge clk)
    begin
        if (srst)
            cmd_ready <= 1'h0;
        else if (take)
            cmd_ready <= 1'h0;
        else
            cmd_ready <= (state_reg == ST_IDLE) || (state_reg == ST_LEN)
                || (state_reg == ST_DATA);
    end

    // ==========================================================
    // packet decode and bit sequencing
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            hdr_reg <= jtag_cmd_pkg::HDR_RESET;
            walk_reg <= 1'h0;
            walk_tdi_reg <= 1'h0;
            packed_reg <= 1'h0;
            data_reg <= 8'h00;
            data_left_reg <= 4'h0;
            bit_cnt_reg <= 8'h00;
            resp_sr_reg <= jtag_cmd_pkg::RESP_RESET;
            resp_cnt_reg <= 3'h0;
            req_tgl_reg <= 1'h0;
            ack_seen_reg <= 1'h0;
            out_tms_reg <= jtag_cmd_pkg::TMS_RESET;
            out_tdi_reg <= jtag_cmd_pkg::TDI_RESET;
            out_cap_reg <= 1'h0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        if (!cmd_data[jtag_cmd_pkg::OP_TOP_BIT])
                        begin
                            walk_reg <= 1'h1; // [R1]
                            packed_reg <= 1'h0;
                            walk_tdi_reg <= cmd_data[jtag_cmd_pkg::WALK_TDI_BIT]; // [R2]
                            data_reg <= {2'h0, cmd_data[5:0]};
                            bit_cnt_reg <= {5'h00, walk_len}; // [R1]
                            state_reg <= (walk_len != 3'h0) ? ST_SHIFT : ST_IDLE;
                        end
                        else if (cmd_data[7:5] == jtag_cmd_pkg::SCAN_OPCODE) // [R6]
                        begin
                            hdr_reg <= cmd_data;
                            walk_reg <= 1'h0;
                            state_reg <= ST_LEN; // [R7]
                        end
                        // other opcodes are dropped here [R21]
                    end
                end
                ST_LEN:
                begin
                    if (take)
                    begin
                        if (cmd_data[jtag_cmd_pkg::LEN_PACKED_BIT]) // [R16]
                        begin
                            packed_reg <= 1'h1;
                            data_reg <= cmd_data; // [R18] [R19]
                            bit_cnt_reg <= {5'h00, packed_len}; // [R20]
                            state_reg <= (packed_len != 3'h0) ? ST_SHIFT : ST_IDLE;
                        end
                        else
                        begin
                            packed_reg <= 1'h0;
                            data_left_reg <= 4'h0;
                            bit_cnt_reg <= {1'h0, cmd_data[6:0]} + 8'h01; // [R14]
                            // fixed input: length byte closes the packet [R15] [R13]
                            state_reg <= hdr_reg[jtag_cmd_pkg::HDR_FIXED_FLAG_BIT]
                                ? ST_SHIFT : ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (take)
                    begin
                        data_reg <= cmd_data; // [R22]
                        data_left_reg <= jtag_cmd_pkg::DATA_BYTE_BITS;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (walk_reg)
                    begin
                        out_tms_reg <= data_reg[0]; // [R4]
                        out_tdi_reg <= walk_tdi_reg; // [R2]
                        out_cap_reg <= 1'h0; // [R3]
                    end
                    else
                    begin
                        out_tms_reg <= last_bit && hdr_reg[jtag_cmd_pkg::HDR_TMS_LAST_BIT]; // [R8] [R9]
                        out_tdi_reg <= hdr_reg[jtag_cmd_pkg::HDR_FIXED_FLAG_BIT]
                            ? hdr_reg[jtag_cmd_pkg::HDR_FIXED_TDI_BIT] : data_reg[0]; // [R12] [R18]
                        out_cap_reg <= hdr_reg[jtag_cmd_pkg::HDR_CAPTURE_BIT]; // [R10] [R11]
                    end
                    req_tgl_reg <= ~req_tgl_reg; // [R5]
                    state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (ack_evt)
                    begin
                        ack_seen_reg <= ack_sync;
                        data_reg <= {1'h0, data_reg[7:1]}; // [R4] [R22]
                        data_left_reg <= data_left_reg - 4'h1;
                        bit_cnt_reg <= bit_cnt_reg - 8'h01;
                        if (out_cap_reg)
                        begin
                            // full or last byte leaves via the response register [R23]
                            resp_sr_reg <= resp_full ? jtag_cmd_pkg::RESP_RESET : resp_merge;
                            resp_cnt_reg <= resp_full ? 3'h0 : resp_cnt_reg + 3'h1;
                        end
                        if (out_cap_reg && resp_full)
                            state_reg <= ST_PUSH; // [R23]
                        else if (last_bit)
                            state_reg <= ST_IDLE;
                        else if (need_data && data_left_reg == 4'h1)
                            state_reg <= ST_DATA; // [R22]
                        else
                            state_reg <= ST_SHIFT;
                    end
                end
                ST_PUSH:
                begin
                    // no further bits while the byte is refused [R24]
                    if (resp_valid && resp_ready)
                    begin
                        if (bit_cnt_reg == 8'h00)
                            state_reg <= ST_IDLE;
                        else if (need_data && data_left_reg == 4'h0)
                            state_reg <= ST_DATA;
                        else
                            state_reg <= ST_SHIFT;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // response output
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            resp_valid <= 1'h0;
            resp_data <= jtag_cmd_pkg::RESP_RESET;
        end
        else if (resp_valid && resp_ready)
            resp_valid <= 1'h0;
        else if (ack_evt && out_cap_reg && resp_full)
        begin
            resp_valid <= 1'h1; // [R23]
            resp_data <= resp_merge; // [R23]
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            busy <= 1'h0;
        else
            busy <= (state_reg != ST_IDLE);
    end

    // ==========================================================
    // link side: one enabled link period per bit
    // tms and tdi keep their last level between bits
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            tck_en <= 1'h0;
            req_seen_reg <= 1'h0;
            ack_tgl_reg <= 1'h0;
            tms <= jtag_cmd_pkg::TMS_RESET;
            tdi <= jtag_cmd_pkg::TDI_RESET;
            lk_cap_reg <= 1'h0;
            tdo_cap_reg <= 1'h0;
        end
        else if (tck_en)
        begin
            tck_en <= 1'h0; // [R5]
            if (lk_cap_reg)
                tdo_cap_reg <= tdo; // [R10]
            ack_tgl_reg <= ~ack_tgl_reg;
        end
        else if (req_sync != req_seen_reg)
        begin
            // bit payload has been stable since the toggle left clk
            req_seen_reg <= req_sync;
            tms <= out_tms_reg;
            tdi <= out_tdi_reg;
            lk_cap_reg <= out_cap_reg;
            tck_en <= 1'h1; // [R5]
        end
    end

    // ==========================================================
    // checks
    a_walk_no_cap: assert property (@(posedge clk) disable iff (srst) // [R3]
        (state_reg == ST_WAIT && walk_reg) |-> !out_cap_reg && !resp_valid)
        else $error("state-walk bit marked for capture");

    a_walk_tdi_hold: assert property (@(posedge clk) disable iff (srst) // [R2]
        (state_reg == ST_WAIT && walk_reg) |-> out_tdi_reg == walk_tdi_reg)
        else $error("state-walk tdi differs from command bit");

    a_last_tms: assert property (@(posedge clk) disable iff (srst) // [R8]
        (state_reg == ST_WAIT && !walk_reg && last_bit)
        |-> out_tms_reg == hdr_reg[jtag_cmd_pkg::HDR_TMS_LAST_BIT])
        else $error("last scan tms wrong");

    a_early_tms_low: assert property (@(posedge clk) disable iff (srst) // [R9]
        (state_reg == ST_WAIT && !walk_reg && bit_cnt_reg > 8'h01) |-> !out_tms_reg)
        else $error("tms high before last scan cycle");

    a_fixed_tdi: assert property (@(posedge clk) disable iff (srst) // [R12]
        (state_reg == ST_WAIT && !walk_reg && hdr_reg[jtag_cmd_pkg::HDR_FIXED_FLAG_BIT])
        |-> out_tdi_reg == hdr_reg[jtag_cmd_pkg::HDR_FIXED_TDI_BIT])
        else $error("fixed tdi not held");

    a_resp_stall: assert property (@(posedge clk) disable iff (srst) // [R24]
        (resp_valid && !resp_ready) |=> resp_valid && $stable(resp_data)
        && state_reg == ST_PUSH)
        else $error("response dropped or scan ran on while stalled");

    a_resp_cause: assert property (@(posedge clk) disable iff (srst) // [R10]
        $rose(resp_valid) |-> $past(out_cap_reg) && !walk_reg
        && hdr_reg[jtag_cmd_pkg::HDR_CAPTURE_BIT])
        else $error("response without capture flag");

    a_shift_req: assert property (@(posedge clk) disable iff (srst) // [R5]
        (state_reg == ST_SHIFT) |=> state_reg == ST_WAIT
        && req_tgl_reg != $past(req_tgl_reg))
        else $error("bit issued without one request");

    a_len_normal: assert property (@(posedge clk) disable iff (srst) // [R14]
        (state_reg == ST_LEN && take && !cmd_data[7])
        |=> bit_cnt_reg == ({1'h0, $past(cmd_data[6:0])} + 8'h01))
        else $error("normal length decoded wrong");

    a_tck_one: assert property (@(posedge link_clk) disable iff (link_rst) // [R5]
        tck_en |=> !tck_en)
        else $error("test clock enable longer than one cycle");

endmodule

/* File: bench/tap_model.sv */
// behavioural test access port standing behind the port multiplexer
// assumes tck_en marks one tck period per bit; tms and tdi are stable while it is high
`timescale 1ns/1ps

module tap_model (
    input wire logic link_clk,
    input wire logic tck_en,
    input wire logic tdi,
    output logic tdo
);
    // ==========================================================
    // data register
    // one port only, so every captured level is defined
    logic [7:0] shift_reg = 8'hA5;

    // tdo shifts out the A5 seed and then the tdi bits shifted in, so a stuck capture shows up
    always @(posedge link_clk)
    begin
        if (tck_en === 1'b1)
        begin
            shift_reg <= {tdi, shift_reg[7:1]};
        end
    end

    assign tdo = shift_reg[0];
endmodule

/* File: bench/tb_jtag_byte_command_engine.sv */
// self-checking bench for the byte command engine
// assumes tap_model as the far side and a free running link clock
`timescale 1ns/1ps

module tb_jtag_byte_command_engine;
    // ==========================================================
    // clocks, wires, bookkeeping
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [7:0] resp_data;
    logic resp_valid;
    logic resp_ready = 1'b0;
    logic tdo, tms, tdi, tck_en, busy;
    logic hold_off = 1'b0;
    logic [3:0] exp_q [$];
    logic [7:0] exp_r [$];
    logic [7:0] acc = 8'h00;
    int nacc = 0;
    int n_bits = 0;
    int n_errors = 0;
    int samples_checked = 0;

    initial forever #2 clk = ~clk;
    initial forever #62.5 link_clk = ~link_clk;

    jtag_byte_command_engine u_dut (
        .clk(clk), .srst(srst), .link_clk(link_clk),
        .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .resp_data(resp_data), .resp_valid(resp_valid), .resp_ready(resp_ready),
        .tdo(tdo), .tms(tms), .tdi(tdi), .tck_en(tck_en), .busy(busy)
    );

    tap_model u_tap (.link_clk(link_clk), .tck_en(tck_en), .tdi(tdi), .tdo(tdo));

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic send_byte(input logic [7:0] b);
        int k;
        @(negedge clk);
        cmd_data = b;
        cmd_valid = 1'b1;
        // ready looked at mid-cycle, away from the edge that moves it
        for (k = 0; k < 20000; k++)
        begin
            if (cmd_ready === 1'b1)
                break;
            @(negedge clk);
        end
        if (k == 20000)
        begin
            check("cmd_ready_wait", 8'h00, 8'h01);
            end_of_test();
        end
        else
        begin
            @(posedge clk);
            @(negedge clk);
            cmd_valid = 1'b0;
        end
    endtask

    // note entry: {capture, last, tms, tdi}
    task automatic walk(input int n, input logic lvl);
        logic [5:0] t;
        t = 6'($urandom) & ((6'h01 << n) - 6'h01);
        for (int i = 0; i < n; i++)
            exp_q.push_back({1'b0, 1'b0, t[i], lvl});
        send_byte({1'b0, lvl, t | (6'h01 << n)});
    endtask

    task automatic scan(input int len, input logic packed_fmt, input logic [3:0] fl);
        logic [127:0] d;
        d = {$urandom, $urandom, $urandom, $urandom};
        if (len < 128)
            d = d & ((128'h1 << len) - 128'h1);
        for (int i = 0; i < len; i++)
            exp_q.push_back({fl[2], i == len - 1, (i == len - 1) ? fl[3] : 1'b0,
                fl[0] ? fl[1] : d[i]});
        send_byte({4'h8, fl});
        if (packed_fmt)
            send_byte(8'h80 | (8'h01 << len) | d[7:0]);
        else
        begin
            send_byte({1'b0, 7'(len - 1)});
            if (!fl[0])
                for (int k = 0; k < (len + 7) / 8; k++)
                    send_byte(d[8*k +: 8]);
        end
    endtask

    task automatic drain();
        int k;
        for (k = 0; k < 30000; k++)
        begin
            @(posedge clk);
            if (exp_q.size() == 0 && exp_r.size() == 0 && busy === 1'b0)
                break;
        end
        check("drain_done", 8'(exp_q.size() + exp_r.size()), 8'h00);
        // a stuck engine with empty notes still counts
        check("drain_busy", {7'h00, busy}, 8'h00);
    endtask

    // ==========================================================
    // monitors
    always @(posedge link_clk)
    begin
        logic [3:0] e;
        if (tck_en === 1'b1)
        begin
            n_bits++;
            if (exp_q.size() == 0)
                check("spare_bit", 8'h01, 8'h00);
            else
            begin
                e = exp_q.pop_front();
                check("tms", {7'h00, tms}, {7'h00, e[1]});
                check("tdi", {7'h00, tdi}, {7'h00, e[0]});
                if (e[3])
                begin
                    acc[nacc] = tdo;
                    nacc++;
                    if (nacc == 8 || e[2])
                    begin
                        exp_r.push_back(acc);
                        acc = 8'h00;
                        nacc = 0;
                    end
                end
            end
        end
    end

    always @(posedge clk)
    begin
        if (resp_valid === 1'b1 && resp_ready === 1'b1)
        begin
            if (exp_r.size() == 0)
                check("spare_resp", 8'h01, 8'h00);
            else
                check("resp_data", resp_data, exp_r.pop_front());
        end
    end

    // ready toggles at random so responses meet back-pressure
    always @(negedge clk)
        resp_ready <= hold_off ? 1'b0 : ($urandom % 4 != 0);

    initial
    begin
        repeat (95000) @(posedge clk);
        check("run_timeout", 8'h00, 8'h01);
        end_of_test();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        int lens [6];
        int base;
        logic [3:0] fl;
        lens = '{1, 7, 8, 9, 21, 128};
        void'($urandom(96));
        // link side resets through its synchroniser, so hold for 12 link clock cycles
        repeat (12) @(posedge link_clk);
        @(negedge clk);
        srst = 1'b0;
        check("busy_idle", {7'h00, busy}, 8'h00);
        // state-walk lengths one to five, both tdi levels
        for (int n = 1; n <= 5; n++)
            walk(n, 1'(n));
        send_byte(8'h40);
        // reserved opcodes followed by a walk that must still decode
        for (int op = 5; op <= 7; op++)
            send_byte({3'(op), 5'($urandom)});
        walk(3, 1'b1);
        drain();
        // packed second byte, every length, both fixed-input settings
        for (int len = 1; len <= 6; len++)
            for (int f = 0; f < 2; f++)
            begin
                fl = 4'($urandom);
                fl[0] = 1'(f);
                scan(len, 1'b1, fl);
            end
        // packed byte with no end marker: no cycles, no response
        send_byte(8'h84);
        send_byte(8'h80);
        drain();
        // normal length byte at the boundaries
        for (int i = 0; i < 6; i++)
        begin
            fl = 4'($urandom);
            if (lens[i] >= 21)
                fl[2] = 1'b1;
            if (lens[i] == 21)
                fl[0] = 1'b0;
            if (lens[i] == 128)
                fl[0] = 1'b1;
            scan(lens[i], 1'b0, fl);
        end
        drain();
        // full response fifo holds the scan after the first byte
        hold_off = 1'b1;
        base = n_bits;
        scan(16, 1'b0, 4'h5);
        repeat (4000) @(posedge clk);
        check("stalled_bits", 8'(n_bits - base), 8'h08);
        hold_off = 1'b0;
        drain();
        end_of_test();
    end
endmodule
